// ### verilog/dsrc_top.sv
// sector read and write-check sequencer with ping-pong buffers and apb registers
//
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module dsrc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire dsrc_pkg::dsrc_pins_t pins,
   output logic separator_enable,
   output logic sector_transfer_request,
   output logic compare_first_byte_load,
   output logic shift_serial_out,
   output dsrc_pkg::dsrc_clk_sel_t clk_sel,
   output logic cpu_interrupt
);
   import dsrc_pkg::*;

   // two flip-flop synchronisers plus an edge history stage
   dsrc_pins_t s1_reg, s2_reg, s3_reg;
   logic e_sep, e_sys, rbit, grant;

   dsrc_state_t st_reg, st_next;
   dsrc_clk_sel_t clk_reg, clk_next;
   logic controller_ready_reg, controller_ready_next, dlt_reg, dlt_next, crc_err_reg, crc_err_next;
   logic mis_reg, mis_next, req_reg, req_next, ie_reg, ie_next, wc_reg, wc_next;
   logic irq_reg, irq_next, sep_reg, sep_next, cfl_reg, cfl_next;
   logic dsro_reg, dsro_next, sel_reg, sel_next, cbuf_reg, cbuf_next;
   logic [1:0] full_reg, full_next;
   logic [8:0] addr_reg, addr_next, cptr_reg, cptr_next;
   logic [2:0] bitc_reg, bitc_next;
   logic [7:0] cnt_reg, cnt_next, sh_reg, sh_next, dsr_reg, dsr_next;
   logic [7:0] stage_reg, stage_next, sh_in;
   logic [15:0] crc_reg, crc_next, crx_reg, crx_next;
   logic [15:0] daddr_reg, daddr_next, tmr_reg, tmr_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pslverr_reg, pslverr_next;

   // two buffers of one sector each
   logic [7:0] mem [0:511];
   logic mem_we;
   logic [8:0] mem_wa;
   logic [7:0] mem_wd;
   logic [7:0] dev_rd, cpu_rd;

   logic acc, wr, rd, sync_hit, cbit;
   dsrc_ctrl_t wctl;
   dsrc_status_t stat;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= pins;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   assign e_sep = s2_reg.separator_clock & ~s3_reg.separator_clock;
   assign e_sys = s2_reg.drive_system_clock & ~s3_reg.drive_system_clock;
   assign rbit = s2_reg.drive_serial_read;
   assign grant = s2_reg.sector_transfer_grant;
   assign dev_rd = mem[{sel_reg, addr_reg[7:0]}];
   assign cpu_rd = mem[{cbuf_reg, cptr_reg[7:0]}];
   assign sh_in = {rbit, sh_reg[7:1]};
   assign sync_hit = e_sep && (sh_in == SYNC_PATTERN);
   assign acc = psel & penable & pready_reg;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign wctl = dsrc_ctrl_t'(pwdata);

   always_comb begin
      stat = '0;
      stat.timer = tmr_reg;
      stat.buffer_full_flag = full_reg;
      stat.buf_sel = sel_reg;
      stat.sector_transfer_request = req_reg;
      stat.mismatch = mis_reg;
      stat.crc_error = crc_err_reg;
      stat.data_late_error = dlt_reg;
      stat.controller_ready = controller_ready_reg;
   end

   always_comb begin
      st_next = st_reg;
      clk_next = clk_reg;
      controller_ready_next = controller_ready_reg;
      dlt_next = dlt_reg;
      crc_err_next = crc_err_reg;
      mis_next = mis_reg;
      req_next = req_reg;
      ie_next = ie_reg;
      wc_next = wc_reg;
      irq_next = irq_reg;
      sep_next = sep_reg;
      cfl_next = 1'b0;
      sel_next = sel_reg;
      cbuf_next = cbuf_reg;
      full_next = full_reg;
      addr_next = addr_reg;
      cptr_next = cptr_reg;
      bitc_next = bitc_reg;
      cnt_next = cnt_reg;
      sh_next = sh_reg;
      dsr_next = dsr_reg;
      stage_next = stage_reg;
      crc_next = crc_reg;
      crx_next = crx_reg;
      daddr_next = daddr_reg;
      tmr_next = (st_reg == S_IDLE) ? tmr_reg : tmr_reg + 16'h1;
      mem_we = 1'b0;
      mem_wa = {cbuf_reg, cptr_reg[7:0]};
      mem_wd = pwdata[7:0];
      cbit = wc_reg ? dsr_reg[0] : rbit;
      prdata_next = prdata_reg;
      pslverr_next = 1'b0;

      // register reads are staged in the setup phase, so the access phase ends in one cycle
      if (psel && !penable) begin
         unique case (paddr)
            A_CTRL: prdata_next = {24'h0, controller_ready_reg, ie_reg, 5'h0, wc_reg};
            A_STAT: prdata_next = stat;
            A_DADDR: prdata_next = {16'h0, daddr_reg};
            A_DATA: prdata_next = {24'h0, cpu_rd};
            default: begin
               prdata_next = RD_ZERO;
               pslverr_next = 1'b1;
            end
         endcase
      end
      if (wr && paddr == A_CTRL) begin
         ie_next = wctl.interrupt_enable;
         controller_ready_next = wctl.controller_ready;
         irq_next = 1'b0;
         if (st_reg == S_IDLE) begin
            wc_next = wctl.write_check;
            if (!wctl.controller_ready) begin
               st_next = S_CHK;
               dlt_next = 1'b0;
               crc_err_next = 1'b0;
               tmr_next = 16'h0;
            end
         end
      end
      if (wr && paddr == A_DADDR) begin
         daddr_next = pwdata[15:0];
      end
      // cpu side of the ping-pong: 256 accesses fill or drain one buffer
      if (acc && paddr == A_DATA) begin
         mem_we = pwrite;
         cptr_next = cptr_reg + 9'h1;
         if (cptr_reg[7:0] == BYTE_LAST) begin
            full_next[cbuf_reg] = pwrite;
            cbuf_next = ~cbuf_reg;
            cptr_next = 9'h0;
         end
      end

      unique case (st_reg)
         S_IDLE: begin
            clk_next = '{CK_CPU, CK_CPU};
         end
         S_CHK: begin
            if (wc_reg ? !full_reg[sel_reg] : full_reg[sel_reg]) begin
               dlt_next = 1'b1;
               mis_next = 1'b0;
               controller_ready_next = 1'b1;
               irq_next = irq_next | ie_reg;
               clk_next = '{CK_CPU, CK_CPU};
               st_next = S_IDLE;
            end else begin
               clk_next = '{CK_SYS, CK_SYS};
               sep_next = 1'b0;
               cnt_next = 8'h0;
               st_next = S_SPL;
            end
         end
         S_SPL: begin
            if (e_sys) begin
               cnt_next = cnt_reg + 8'h1;
               if (cnt_reg == SPLICE_LAST) begin
                  crc_next = CRC_INIT;
                  sep_next = 1'b1;
                  cnt_next = 8'h0;
                  st_next = S_LCK;
               end
            end
         end
         S_LCK: begin
            // read counts recovered pulses, write check counts system clock pulses
            if (wc_reg ? e_sys : e_sep) begin
               cnt_next = cnt_reg + 8'h1;
               if (cnt_reg == LOCK_LAST) begin
                  addr_next = 9'h0;
                  sh_next = 8'h0;
                  clk_next = '{CK_STOP, CK_SEP};
                  if (wc_reg) begin
                     stage_next = mem[{sel_reg, 8'h0}];
                     mis_next = 1'b0;
                  end
                  st_next = S_SYN;
               end
            end
         end
         S_SYN: begin
            if (e_sep) begin
               sh_next = sh_in;
            end
            if (sync_hit) begin
               clk_next = '{CK_SEP, CK_SEP};
               bitc_next = 3'h0;
               if (wc_reg) begin
                  cfl_next = 1'b1;
                  dsr_next = stage_reg;
                  addr_next = 9'h1;
               end
               st_next = S_DAT;
            end
         end
         S_DAT: begin
            if (e_sep) begin
               crc_next = {crc_reg[14:0], 1'b0} ^
                  ((cbit ^ crc_reg[15]) ? CRC_POLY : 16'h0);
               bitc_next = bitc_reg + 3'h1;
               if (wc_reg) begin
                  if (rbit != dsr_reg[0]) begin
                     mis_next = 1'b1;
                  end
                  dsr_next = {1'b0, dsr_reg[7:1]};
               end else begin
                  sh_next = sh_in;
               end
               if (bitc_reg == BIT_LAST) begin
                  if (!wc_reg) begin
                     mem_we = 1'b1;
                     mem_wa = {sel_reg, addr_reg[7:0]};
                     mem_wd = sh_in;
                     addr_next = addr_reg + 9'h1;
                     if (addr_reg[7:0] == BYTE_LAST) begin
                        cnt_next = 8'h0;
                        st_next = S_CRW;
                     end
                  end else if (addr_reg[8]) begin
                     cnt_next = 8'h0;
                     st_next = S_CRW;
                  end else begin
                     dsr_next = dev_rd;
                     addr_next = addr_reg + 9'h1;
                  end
               end
            end
         end
         S_CRW: begin
            if (e_sep) begin
               crx_next = {crx_reg[14:0], rbit};
               cnt_next = cnt_reg + 8'h1;
               if (cnt_reg == CRC_BIT_LAST) begin
                  st_next = S_EVL;
               end
            end
         end
         S_EVL: begin
            clk_next = '{CK_CPU, CK_CPU};
            sep_next = 1'b0;
            if (crx_reg != crc_reg) begin
               crc_err_next = 1'b1;
               controller_ready_next = 1'b1;
               irq_next = irq_next | ie_reg;
               st_next = S_IDLE;
            end else begin
               addr_next = 9'h0;
               req_next = 1'b1;
               full_next[sel_reg] = !wc_reg;
               st_next = S_REQ;
            end
         end
         S_REQ: begin
            if (grant) begin
               req_next = 1'b0;
               sel_next = ~sel_reg;
               st_next = S_GNT;
            end
         end
         S_GNT: begin
            if (controller_ready_reg) begin
               controller_ready_next = 1'b1;
               irq_next = irq_next | ie_reg;
               st_next = S_IDLE;
            end else begin
               daddr_next = daddr_reg + 16'h1;
               tmr_next = 16'h0;
               st_next = S_CHK;
            end
         end
         default: begin
            st_next = S_IDLE;
         end
      endcase
      // cpu data writes lose to a device store in the same cycle
      if (mem_we && !wr) begin
         mem_we = 1'b1;
      end
      dsro_next = dsr_next[0];
   end

   always_ff @(posedge pclk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= S_IDLE;
         clk_reg <= '{CK_CPU, CK_CPU};
         controller_ready_reg <= 1'b1;
         dlt_reg <= 1'b0;
         crc_err_reg <= 1'b0;
         mis_reg <= 1'b0;
         req_reg <= 1'b0;
         ie_reg <= 1'b0;
         wc_reg <= 1'b0;
         irq_reg <= 1'b0;
         sep_reg <= 1'b0;
         cfl_reg <= 1'b0;
         dsro_reg <= 1'b0;
         sel_reg <= 1'b0;
         cbuf_reg <= 1'b0;
         full_reg <= 2'h0;
         addr_reg <= 9'h0;
         cptr_reg <= 9'h0;
         bitc_reg <= 3'h0;
         cnt_reg <= 8'h0;
         sh_reg <= 8'h0;
         dsr_reg <= 8'h0;
         stage_reg <= 8'h0;
         crc_reg <= CRC_INIT;
         crx_reg <= 16'h0;
         daddr_reg <= 16'h0;
         tmr_reg <= 16'h0;
         prdata_reg <= RD_ZERO;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         clk_reg <= clk_next;
         controller_ready_reg <= controller_ready_next;
         dlt_reg <= dlt_next;
         crc_err_reg <= crc_err_next;
         mis_reg <= mis_next;
         req_reg <= req_next;
         ie_reg <= ie_next;
         wc_reg <= wc_next;
         irq_reg <= irq_next;
         sep_reg <= sep_next;
         cfl_reg <= cfl_next;
         dsro_reg <= dsro_next;
         sel_reg <= sel_next;
         cbuf_reg <= cbuf_next;
         full_reg <= full_next;
         addr_reg <= addr_next;
         cptr_reg <= cptr_next;
         bitc_reg <= bitc_next;
         cnt_reg <= cnt_next;
         sh_reg <= sh_next;
         dsr_reg <= dsr_next;
         stage_reg <= stage_next;
         crc_reg <= crc_next;
         crx_reg <= crx_next;
         daddr_reg <= daddr_next;
         tmr_reg <= tmr_next;
         prdata_reg <= prdata_next;
         pready_reg <= 1'b1;
         pslverr_reg <= pslverr_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign separator_enable = sep_reg;
   assign sector_transfer_request = req_reg;
   assign compare_first_byte_load = cfl_reg;
   assign shift_serial_out = dsro_reg;
   assign clk_sel = clk_reg;
   assign cpu_interrupt = irq_reg;

   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_late;
      st_reg == S_CHK && (wc_reg ? !full_reg[sel_reg] : full_reg[sel_reg]);
   endsequence
   sequence s_sync;
      st_reg == S_SYN && sync_hit;
   endsequence
   sequence s_good;
      st_reg == S_EVL && crx_reg == crc_reg;
   endsequence

   late_abort_a: assert property (s_late |=> dlt_reg && controller_ready_reg && !mis_reg
      && st_reg == S_IDLE && cpu_interrupt == $past(ie_reg))
      else $error("late buffer not aborted");
   sys_clock_a: assert property (st_reg == S_CHK
      && (wc_reg ? full_reg[sel_reg] : !full_reg[sel_reg])
      |=> clk_reg == {CK_SYS, CK_SYS} && !sep_reg)
      else $error("system clock not selected");
   splice_end_a: assert property (st_reg == S_SPL && st_next == S_LCK
      |=> sep_reg && crc_reg == CRC_INIT)
      else $error("separator not enabled after splice");
   lock_count_a: assert property (st_reg == S_LCK ##1 st_reg == S_SYN
      |-> $past(cnt_reg) == LOCK_LAST && addr_reg == 9'h0)
      else $error("lock count wrong");
   sync_stall_a: assert property (st_reg == S_SYN
      |-> clk_reg == {CK_STOP, CK_SEP})
      else $error("sequencer not stalled");
   sync_found_a: assert property (s_sync |=> st_reg == S_DAT
      && clk_reg.seq == CK_SEP ##1 st_reg == S_DAT)
      else $error("sync not taken");
   back_cpu_a: assert property (st_reg == S_EVL
      |=> clk_reg == {CK_CPU, CK_CPU})
      else $error("clocks not back on cpu");
   crc_fail_a: assert property (st_reg == S_EVL && crx_reg != crc_reg
      |=> controller_ready_reg && crc_err_reg && st_reg == S_IDLE)
      else $error("crc error not ended");
   good_req_a: assert property (s_good |=> req_reg && addr_reg == 9'h0)
      else $error("request not raised");
   grant_swap_a: assert property (st_reg == S_REQ && grant
      |=> !req_reg && sel_reg != $past(sel_reg))
      else $error("grant not handled");
   run_end_a: assert property (st_reg == S_GNT && controller_ready_reg
      |=> st_reg == S_IDLE && controller_ready_reg)
      else $error("run did not end");
   wc_load_a: assert property (s_sync ##0 wc_reg
      |=> compare_first_byte_load && addr_reg == 9'h1 ##1 !compare_first_byte_load)
      else $error("compare load missing");
   wc_cmp_a: assert property (st_reg == S_DAT && wc_reg && e_sep
      && rbit != dsr_reg[0] |=> mis_reg)
      else $error("mismatch not flagged");
   idle_clk_a: assert property (st_reg == S_IDLE
      |-> clk_reg == {CK_CPU, CK_CPU})
      else $error("idle not on cpu clock");
endmodule : dsrc_top

// ### verilog/dsrc_pkg.sv
// constants and types for the sector read and write-check block
package dsrc_pkg;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STAT = 8'h04;
   localparam logic [7:0] A_DADDR = 8'h08;
   localparam logic [7:0] A_DATA = 8'h0c;
   localparam logic [7:0] SYNC_PATTERN = 8'h80;
   localparam logic [7:0] LOCK_PULSES = 8'h20;
   localparam logic [7:0] LOCK_LAST = LOCK_PULSES - 8'h01;
   localparam logic [7:0] SPLICE_TICKS = 8'h10;
   localparam logic [7:0] SPLICE_LAST = SPLICE_TICKS - 8'h01;
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [7:0] CRC_BIT_LAST = 8'h0f;
   localparam logic [7:0] BYTE_LAST = 8'hff;
   localparam logic [31:0] RD_ZERO = 32'h0;

   typedef enum logic [1:0] {
      CK_CPU = 2'h0,
      CK_SYS = 2'h1,
      CK_SEP = 2'h2,
      CK_STOP = 2'h3
   } dsrc_ck_t;

   // sequencer clock and datapath clock selects
   typedef struct packed {
      dsrc_ck_t seq;
      dsrc_ck_t dp;
   } dsrc_clk_sel_t;

   // drive and cpu side pins, all asynchronous to pclk
   typedef struct packed {
      logic separator_clock;
      logic drive_system_clock;
      logic drive_serial_read;
      logic sector_transfer_grant;
   } dsrc_pins_t;

   typedef struct packed {
      logic [23:0] rsv_h;
      logic controller_ready;
      logic interrupt_enable;
      logic [4:0] rsv_m;
      logic write_check;
   } dsrc_ctrl_t;

   typedef struct packed {
      logic [15:0] timer;
      logic [7:0] rsv;
      logic [1:0] buffer_full_flag;
      logic buf_sel;
      logic sector_transfer_request;
      logic mismatch;
      logic crc_error;
      logic data_late_error;
      logic controller_ready;
   } dsrc_status_t;

   typedef enum logic [9:0] {
      S_IDLE = 10'h001,
      S_CHK = 10'h002,
      S_SPL = 10'h004,
      S_LCK = 10'h008,
      S_SYN = 10'h010,
      S_DAT = 10'h020,
      S_CRW = 10'h040,
      S_EVL = 10'h080,
      S_REQ = 10'h100,
      S_GNT = 10'h200
   } dsrc_state_t;
endpackage : dsrc_pkg

// ### sim/dsrc_drive_model.sv
// behavioural cartridge drive: free system clock, framed separator clock and read data
`timescale 1ns/100ps
module dsrc_drive_model
   import dsrc_pkg::*;
(
   input wire logic separator_enable,
   input wire logic bad_crc,
   input wire logic bad_data,
   output logic separator_clock,
   output logic drive_system_clock,
   output logic drive_serial_read
);
   logic [15:0] crc_reg;
   logic [7:0] byte_v;

   // the data line changes while the clock is low, so every rising edge sees a settled bit
   task automatic send(input logic b);
      drive_serial_read = b;
      #160 separator_clock = 1'b1;
      #160 separator_clock = 1'b0;
   endtask : send

   initial begin
      drive_system_clock = 1'b0;
      forever #160 drive_system_clock = ~drive_system_clock;
   end

   initial begin
      separator_clock = 1'b0;
      drive_serial_read = 1'b1;
      forever begin
         @(posedge separator_enable);
         crc_reg = CRC_INIT;
         // long zero preamble outlasts the lock count
         for (int i = 0; i < 48; i++) send(1'b0);
         for (int i = 0; i < 8; i++) send(SYNC_PATTERN[i]);
         for (int i = 0; i < 2048; i++) begin
            byte_v = 8'(i / 8) ^ 8'ha5;
            crc_reg = {crc_reg[14:0], 1'b0} ^ ((byte_v[i % 8] ^ crc_reg[15]) ? CRC_POLY : 16'h0);
            // a flipped first data bit, crc still over the true data
            send(byte_v[i % 8] ^ (bad_data && i == 0));
         end
         for (int i = 15; i >= 0; i--) send(crc_reg[i] ^ bad_crc);
         // clock stands still; line shows no stale level
         drive_serial_read = ~drive_serial_read;
      end
   end
endmodule : dsrc_drive_model

// ### sim/dsrc_top_tb.sv
// self-checking bench for the sector read and write-check block
`timescale 1ns/100ps
module dsrc_top_tb;
   import dsrc_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] e; logic [31:0] m; logic er;} dsrc_row_t;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, grant, bad_crc, bad_data;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, s;
   logic sclk, sysclk, serial, separator_enable, sector_transfer_request;
   logic compare_first_byte_load, shift_serial_out, cpu_interrupt, e;
   dsrc_pins_t pins;
   dsrc_clk_sel_t clk_sel;
   int checks = 0;
   int n_mismatch = 0;
   int cyc = 0;
   dsrc_row_t rows [4] = '{'{A_STAT, 32'h1, 32'hff, 1'b0}, '{A_DADDR, 32'h5, 32'hffff, 1'b0},
      '{8'h10, 32'h0, 32'hffffffff, 1'b1}, '{8'hfc, 32'h0, 32'hffffffff, 1'b1}};

   assign pins = {sclk, sysclk, serial, grant};

   dsrc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pins(pins), .separator_enable(separator_enable),
      .sector_transfer_request(sector_transfer_request),
      .compare_first_byte_load(compare_first_byte_load), .shift_serial_out(shift_serial_out),
      .clk_sel(clk_sel), .cpu_interrupt(cpu_interrupt));

   dsrc_drive_model drv (.separator_enable(separator_enable), .bad_crc(bad_crc),
      .bad_data(bad_data),
      .separator_clock(sclk), .drive_system_clock(sysclk), .drive_serial_read(serial));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic conclude;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         n_mismatch++;
         $display("CHECK FAILED %0t timeout", $time);
         conclude();
      end
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : cmp

   // one apb transfer; request held until pready is seen high at an access edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk iff pready === 1'b1);
      s = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wait_ready;
      do apb(1'b0, A_STAT, 32'h0); while (s[0] !== 1'b1);
   endtask : wait_ready

   task automatic grant_cycle;
      grant <= 1'b1;
      @(posedge pclk iff sector_transfer_request === 1'b0);
      grant <= 1'b0;
   endtask : grant_cycle

   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, grant, bad_crc, bad_data} = 6'h0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (6) @(posedge pclk);
      cmp(32'(clk_sel), 32'({CK_CPU, CK_CPU}), "reset clocks");
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b1, A_DADDR, 32'h5);
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 32'h0);
         cmp(s & rows[i].m, rows[i].e, "register row");
         cmp(32'(e), 32'(rows[i].er), "slave error row");
      end
      $display("test registers done");
      apb(1'b1, A_CTRL, 32'h40);
      @(posedge pclk iff separator_enable === 1'b1);
      cmp(32'(clk_sel), 32'({CK_SYS, CK_SYS}), "clocks before lock");
      @(posedge pclk iff clk_sel.seq === CK_STOP);
      cmp(32'(clk_sel.dp), 32'(CK_SEP), "sync hunt datapath");
      @(posedge pclk iff sector_transfer_request === 1'b1);
      cmp(32'(clk_sel), 32'({CK_CPU, CK_CPU}), "clocks after crc");
      apb(1'b0, A_STAT, 32'h0);
      cmp(s & 32'hf7, 32'h50, "first sector status");
      grant_cycle();
      apb(1'b0, A_DADDR, 32'h0);
      cmp(s & 32'hffff, 32'h6, "disk address step");
      @(posedge pclk iff sector_transfer_request === 1'b1);
      apb(1'b0, A_STAT, 32'h0);
      cmp(s & 32'hf7, 32'hf0, "second sector status");
      apb(1'b1, A_CTRL, 32'hc0);
      grant_cycle();
      @(posedge pclk iff cpu_interrupt === 1'b1);
      apb(1'b0, A_STAT, 32'h0);
      cmp(s & 32'h37, 32'h01, "run end status");
      $display("test multi-sector read done");
      apb(1'b1, A_CTRL, 32'h40);
      @(posedge pclk iff cpu_interrupt === 1'b1);
      apb(1'b0, A_STAT, 32'h0);
      cmp(s & 32'h1f, 32'h03, "read into full buffer");
      cmp(32'(clk_sel), 32'({CK_CPU, CK_CPU}), "idle clocks");
      for (int i = 0; i < 512; i++) begin
         apb(1'b0, A_DATA, 32'h0);
         cmp(s & 32'hff, 32'(8'(i) ^ 8'ha5), "sector byte");
      end
      $display("test full buffer and drain done");
      bad_crc <= 1'b1;
      apb(1'b1, A_CTRL, 32'h00);
      wait_ready();
      cmp(s & 32'h17, 32'h05, "crc error status");
      cmp(32'(cpu_interrupt), 32'h0, "no interrupt when disabled");
      bad_crc <= 1'b0;
      $display("test crc error done");
      apb(1'b1, A_CTRL, 32'h41);
      @(posedge pclk iff cpu_interrupt === 1'b1);
      apb(1'b0, A_STAT, 32'h0);
      cmp(s & 32'h1f, 32'h03, "write check unfilled");
      cmp(32'(clk_sel), 32'({CK_CPU, CK_CPU}), "write check unfilled clocks");
      for (int i = 0; i < 256; i++) apb(1'b1, A_DATA, 32'(8'(i) ^ 8'ha5));
      apb(1'b1, A_CTRL, 32'h01);
      @(posedge pclk iff clk_sel === {CK_SYS, CK_SYS});
      cmp(32'(separator_enable), 32'h0, "separator off in splice");
      @(posedge pclk iff compare_first_byte_load === 1'b1);
      cmp(32'(shift_serial_out), 32'h1, "first byte bit 0 staged");
      @(posedge pclk iff sector_transfer_request === 1'b1);
      apb(1'b0, A_STAT, 32'h0);
      cmp(s & 32'h1f, 32'h10, "write check match");
      $display("test write check done");
      apb(1'b1, A_CTRL, 32'h80);
      grant_cycle();
      apb(1'b0, A_STAT, 32'h0);
      cmp(s & 32'h3f, 32'h21, "write check run end");
      for (int i = 0; i < 256; i++) apb(1'b1, A_DATA, 32'(8'(i) ^ 8'ha5));
      bad_data <= 1'b1;
      apb(1'b1, A_CTRL, 32'h01);
      do apb(1'b0, A_STAT, 32'h0); while (s[3] !== 1'b1);
      cmp(s & 32'h3f, 32'h28, "write check mismatch");
      bad_data <= 1'b0;
      $display("test write check mismatch done");
      // reset lands while the sector is still streaming in
      presetn <= 1'b0;
      @(posedge pclk);
      cmp(32'(clk_sel), 32'({CK_CPU, CK_CPU}), "mid-run reset clocks");
      cmp(32'(sector_transfer_request), 32'h0, "mid-run reset request");
      cmp(32'(separator_enable), 32'h0, "mid-run reset separator");
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, A_STAT, 32'h0);
      cmp(s & 32'hff, 32'h01, "status after reset release");
      $display("test mid-run reset done");
      conclude();
   end
endmodule : dsrc_top_tb
